// >>> hw/upsr_pkg.sv
// Shared constants and types for the USB port suspend/resume control block
package upsr_pkg;
    localparam int CLK_HZ          = 20_000_000;
    localparam int CLK_PERIOD_PS   = 50_000;
    // Bus idle after resume before the first SOF, in picoseconds (1.333 us)
    localparam int SOF_IDLE_PS     = 1_333_000;
    // Least time rounds up to whole cycles
    localparam int SOF_IDLE_CYC    =
        (SOF_IDLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SOF_CNT_W       = 6;
    localparam logic [SOF_CNT_W-1:0] SOF_CNT_RESET = 6'h00;
    localparam int PWD_W           = 5;
    localparam logic [PWD_W-1:0]   PWD_ALL  = 5'h1f;
    localparam int FIFO_W          = 32;
    localparam int FIFO_DEPTH      = 32;
    localparam int LEN_W           = 10;
    localparam int THR_W           = 6;
    localparam logic [THR_W-1:0]   THR_RESET = 6'h01;
    localparam int RETRY_RESET     = 0;

    // Resume sequencing toward the transceiver macro
    typedef enum logic [4:0] {
        upsr_rs_idle  = 5'b00001,
        upsr_rs_k     = 5'b00010,
        upsr_rs_se0   = 5'b00100,
        upsr_rs_hs    = 5'b01000,
        upsr_rs_wait  = 5'b10000
    } upsr_rs_t;

    // Transmit packet engine
    typedef enum logic [2:0] {
        upsr_tx_idle = 3'b001,
        upsr_tx_send = 3'b010,
        upsr_tx_fail = 3'b100
    } upsr_tx_t;
endpackage

// >>> hw/upsr_fifo_if.sv
// Valid/ready carrier between the port controller and its FIFO
`timescale 1ns/1ps
interface upsr_fifo_if #(parameter int W = 32, parameter int AW = 6);
    logic          in_valid;
    logic          in_ready;
    logic [W-1:0]  in_data;
    logic          out_valid;
    logic          out_ready;
    logic [W-1:0]  out_data;
    logic [AW-1:0] level;
    modport fifo (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data, level);
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data, level);
endinterface

// >>> hw/upsr_fifo.sv
// Synchronous FIFO with registered read data
`timescale 1ns/1ps
module upsr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic  clock,
    input  wire logic  reset,
    upsr_fifo_if.fifo  port
);
    localparam int AW = $clog2(DEPTH);
    // Refuse depths that the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("upsr_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [WIDTH-1:0] out_data;
    logic             out_valid;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic [WIDTH-1:0] next_out_data;
    logic             next_out_valid;
    logic             push;
    logic             pop;
    logic             load;

    // Output register acts as one of the DEPTH slots so read data come from a flop
    always_comb begin
        push           = port.in_valid && port.in_ready;
        load           = (count != '0) && (!out_valid || port.out_ready);
        pop            = load;
        next_wr_ptr    = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr    = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count     = (AW+1)'(count + push - pop);
        next_out_data  = load ? mem[rd_ptr] : out_data;
        next_out_valid = load ? 1'b1
                       : (port.out_ready ? 1'b0 : out_valid);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
        end
        if (push)
            mem[wr_ptr] <= port.in_data;
    end

    // Output slot counts toward the depth, so no more than DEPTH words sit here
    assign port.in_ready  = (count + (AW+1)'(out_valid)) != (AW+1)'(DEPTH);
    assign port.out_valid = out_valid;
    assign port.out_data  = out_data;
    assign port.level     = count;
endmodule

// >>> hw/upsr_port_ctrl.sv
// USB port suspend, resume, transmit streaming and charger control
//
// Function
// [R1] Device mode: software suspends PHY only when stopped or bus suspended.
// [R2] Device mode: host resume clears PHY low-power suspend bit in hardware.
// [R3] Software clears PHY low-power suspend before device forces resume.
// [R4] Host mode: software suspends PHY only after port suspend or detach.
// [R5] Software sets suspend bit, then power-down bits, then clock gate.
// [R6] Wakeup with suspend bit clear raises port change, leaves bit clear.
// [R7] Wakeup after suspend bit set, before power-down, raises wakeup irq.
// [R8] Resume: macro drives K then SE0; switch to HS; then SOF allowed.
// [R9] Host holds SE0 idle 1.333 us after resume before first SOF.
// [R10] Software disables HS disconnect detect in suspend, re-enables after.
// [R11] Host streaming underrun on OUT data retries that OUT transaction.
// [R12] Software starts host OUT buffers on 4-byte aligned addresses.
// [R13] Stream disable: whole packet is buffered before transmit begins.
// [R14] Programmable fill threshold delays transmit until more data buffered.
// [R15] Writing 1 to active-low charger detect enable disables charger detect.
// [R16] Retry and stream disable apply to host and dual-role-as-host alike.
// [R17] Device mode stream disable also prevents receive FIFO overruns; this block has no receive FIFO, stream_disable only gates transmit start.
// [R18] All power-down bits plus clock gate stop transceiver clock.
`timescale 1ns/1ps
module upsr_port_ctrl
    import upsr_pkg::*;
#(
    parameter int LEN_BITS = upsr_pkg::LEN_W
) (
    input  wire logic                     clock,
    input  wire logic                     reset,
    input  wire logic                     host_mode,
    input  wire logic                     suspend_set,
    input  wire logic                     suspend_clear,
    input  wire logic                     port_suspend,
    input  wire logic [upsr_pkg::PWD_W-1:0] phy_powerdown_bits,
    input  wire logic                     phy_clock_gate,
    input  wire logic                     resume_pin,
    input  wire logic                     wakeup_pin,
    input  wire logic                     stream_disable,
    input  wire logic [upsr_pkg::THR_W-1:0] tx_fill_threshold,
    input  wire logic                     chg_detect_enable_n,
    input  wire logic                     hs_disconnect_detect_enable,
    input  wire logic                     se0_seen,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [upsr_pkg::FIFO_W-1:0] in_data,
    input  wire logic [LEN_BITS-1:0]      pkt_words,
    input  wire logic                     pkt_start,
    input  wire logic                     tx_ready,
    output logic                          tx_valid,
    output logic [upsr_pkg::FIFO_W-1:0]   tx_data,
    output logic                          tx_underrun_retry,
    output logic                          phy_low_power_suspend,
    output logic                          port_change_irq,
    output logic                          remote_wakeup_irq,
    output logic                          xcvr_clock_run,
    output logic                          drive_fs_k,
    output logic                          drive_se0,
    output logic                          high_speed,
    output logic                          sof_allowed,
    output logic                          hs_disc_detect_active,
    output logic                          charger_detect_on
);
    import upsr_pkg::*;
    localparam int AW = $clog2(FIFO_DEPTH) + 1;
    initial begin
        if (LEN_BITS < 2 || LEN_BITS > 16)
            $error("upsr_port_ctrl: LEN_BITS out of range");
    end

    // Pin synchronisers: three flops, change counted when last two agree
    logic [2:0] res_sync;
    logic [2:0] wak_sync;
    logic       res_lvl;
    logic       wak_lvl;
    logic       wak_prev;
    logic       next_res_lvl;
    logic       next_wak_lvl;
    always_comb begin
        next_res_lvl = (res_sync[2] == res_sync[1]) ? res_sync[1] : res_lvl;
        next_wak_lvl = (wak_sync[2] == wak_sync[1]) ? wak_sync[1] : wak_lvl;
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            res_sync <= 3'h0;
            wak_sync <= 3'h0;
            res_lvl  <= 1'b0;
            wak_lvl  <= 1'b0;
            wak_prev <= 1'b0;
        end else begin
            res_sync <= {res_sync[1:0], resume_pin};
            wak_sync <= {wak_sync[1:0], wakeup_pin};
            res_lvl  <= next_res_lvl;
            wak_lvl  <= next_wak_lvl;
            wak_prev <= wak_lvl;
        end
    end
    logic wake_evt;
    assign wake_evt = wak_lvl && !wak_prev;

    // Low-power suspend bit; hardware clear on host resume beats a set
    logic next_lps;
    logic pwd_full;
    assign pwd_full = (phy_powerdown_bits == PWD_ALL);
    always_comb begin
        next_lps = phy_low_power_suspend;
        if (suspend_set)
            next_lps = 1'b1;
        if (suspend_clear)
            next_lps = 1'b0;
        if (!host_mode && res_lvl)
            next_lps = 1'b0;                          // [R2]
    end
    always_ff @(posedge clock) begin
        if (reset)
            phy_low_power_suspend <= 1'b0;
        else
            phy_low_power_suspend <= next_lps;
    end

    // Wakeup interrupts: one-cycle pulses, bit left untouched
    logic next_pci;
    logic next_rwi;
    always_comb begin
        next_pci = wake_evt && port_suspend && !phy_low_power_suspend; // [R6]
        next_rwi = wake_evt && phy_low_power_suspend
                   && !(pwd_full && phy_clock_gate);                  // [R7]
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            port_change_irq   <= 1'b0;
            remote_wakeup_irq <= 1'b0;
        end else begin
            port_change_irq   <= next_pci;
            remote_wakeup_irq <= next_rwi;
        end
    end

    // Transceiver clock stops only when fully powered down and gated
    assign xcvr_clock_run = !(phy_low_power_suspend && pwd_full
                              && phy_clock_gate && !wak_lvl);  // [R18]
    assign charger_detect_on = !chg_detect_enable_n;            // [R15]
    assign hs_disc_detect_active = hs_disconnect_detect_enable
                                   && !port_suspend;

    // Resume sequence: K, SE0, switch to HS on SE0, then hold idle
    upsr_rs_t               rs_state;
    upsr_rs_t               next_rs_state;
    logic [SOF_CNT_W-1:0]   idle_cnt;
    logic [SOF_CNT_W-1:0]   next_idle_cnt;
    logic                   next_high_speed;
    always_comb begin
        next_rs_state   = rs_state;
        next_idle_cnt   = idle_cnt;
        next_high_speed = high_speed;
        unique case (rs_state)
            upsr_rs_idle:
                if (host_mode && port_suspend && res_lvl)
                    next_rs_state = upsr_rs_k;
            upsr_rs_k:
                if (!res_lvl)
                    next_rs_state = upsr_rs_se0;              // [R8]
            upsr_rs_se0:
                if (se0_seen)
                    next_rs_state = upsr_rs_hs;               // [R8]
            upsr_rs_hs: begin
                next_rs_state   = upsr_rs_wait;
                next_idle_cnt   = SOF_CNT_RESET;
                next_high_speed = 1'b1;                       // [R8]
            end
            upsr_rs_wait: begin
                next_idle_cnt = SOF_CNT_W'(idle_cnt + 1'b1);
                if (idle_cnt == SOF_CNT_W'(SOF_IDLE_CYC - 1))
                    next_rs_state = upsr_rs_idle;             // [R9]
            end
            default:
                next_rs_state = upsr_rs_idle;
        endcase
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            rs_state <= upsr_rs_idle;
            idle_cnt <= SOF_CNT_RESET;
            high_speed <= 1'b0;
        end else begin
            rs_state <= next_rs_state;
            idle_cnt <= next_idle_cnt;
            high_speed <= next_high_speed;
        end
    end
    assign drive_fs_k  = (rs_state == upsr_rs_k);
    assign drive_se0   = (rs_state == upsr_rs_se0);
    assign sof_allowed = (rs_state == upsr_rs_idle) && !port_suspend;

    // Transmit FIFO between system side and the link
    upsr_fifo_if #(.W(FIFO_W), .AW(AW)) fif ();
    upsr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock (clock),
        .reset (reset),
        .port  (fif.fifo)
    );
    assign fif.in_valid = in_valid;
    assign fif.in_data  = in_data;
    assign in_ready     = fif.in_ready;

    // Transmit engine: start gated by whole packet or fill threshold
    upsr_tx_t          tx_state;
    upsr_tx_t          next_tx_state;
    logic [LEN_BITS-1:0] left;
    logic [LEN_BITS-1:0] next_left;
    logic              start_ok;
    logic [LEN_BITS-1:0] need;
    always_comb begin
        need = stream_disable ? pkt_words                     // [R13] [R17]
             : LEN_BITS'(tx_fill_threshold);                  // [R14]
        start_ok = (LEN_BITS'(fif.level) + LEN_BITS'(fif.out_valid)) >= need;
        next_tx_state = tx_state;
        next_left     = left;
        unique case (tx_state)
            upsr_tx_idle:
                if (pkt_start && start_ok && pkt_words != '0) begin
                    next_tx_state = upsr_tx_send;
                    next_left     = pkt_words;
                end
            upsr_tx_send:
                if (!fif.out_valid)
                    next_tx_state = upsr_tx_fail;             // [R11] [R16]
                else if (tx_ready) begin
                    next_left = LEN_BITS'(left - 1'b1);
                    if (left == LEN_BITS'(1))
                        next_tx_state = upsr_tx_idle;
                end
            upsr_tx_fail:
                next_tx_state = upsr_tx_idle;
            default:
                next_tx_state = upsr_tx_idle;
        endcase
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_state <= upsr_tx_idle;
            left     <= '0;
        end else begin
            tx_state <= next_tx_state;
            left     <= next_left;
        end
    end
    assign tx_valid          = (tx_state == upsr_tx_send) && fif.out_valid;
    assign tx_data           = fif.out_data;
    assign fif.out_ready     = (tx_state == upsr_tx_send) && tx_ready;
    assign tx_underrun_retry = (tx_state == upsr_tx_fail); // [R11]

    // Suspend, wakeup, resume, transmit, charger and clock checks
    sequence s_res_done;
        (rs_state == upsr_rs_hs) ##1 (rs_state == upsr_rs_wait);
    endsequence
    property p_hw_clear;
        @(posedge clock) disable iff (reset)
        (!host_mode && res_lvl) |=> !phy_low_power_suspend;
    endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("lps kept"); // [R2]
    property p_pci;
        @(posedge clock) disable iff (reset)
        (wake_evt && port_suspend && !phy_low_power_suspend && !suspend_set)
        |=> port_change_irq && !phy_low_power_suspend;
    endproperty
    a_pci: assert property (p_pci) else $error("port change missing"); // [R6]
    property p_rwi;
        @(posedge clock) disable iff (reset)
        (wake_evt && phy_low_power_suspend && !pwd_full) |=> remote_wakeup_irq;
    endproperty
    a_rwi: assert property (p_rwi) else $error("wakeup irq missing"); // [R7]
    property p_se0_hs;
        @(posedge clock) disable iff (reset)
        (drive_se0 && se0_seen) |=> (rs_state == upsr_rs_hs) ##1 high_speed;
    endproperty
    a_se0_hs: assert property (p_se0_hs) else $error("no HS switch"); // [R8]
    property p_idle;
        @(posedge clock) disable iff (reset)
        s_res_done |-> !sof_allowed [*8];
    endproperty
    a_idle: assert property (p_idle) else $error("SOF too early"); // [R9]
    property p_retry;
        @(posedge clock) disable iff (reset)
        (tx_state == upsr_tx_send && !fif.out_valid) |=> tx_underrun_retry
        ##1 (tx_state == upsr_tx_idle);
    endproperty
    a_retry: assert property (p_retry) else $error("no retry"); // [R11]
    property p_stream_disable;
        @(posedge clock) disable iff (reset)
        (tx_state == upsr_tx_idle && pkt_start && stream_disable
         && pkt_words != '0 && $past(tx_state) == upsr_tx_idle)
        ##1 (tx_state == upsr_tx_send)
        |-> $past(start_ok);
    endproperty
    a_stream_disable: assert property (p_stream_disable) else $error("start before full"); // [R13]
    property p_chg;
        @(posedge clock) disable iff (reset)
        chg_detect_enable_n |-> !charger_detect_on;
    endproperty
    a_chg: assert property (p_chg) else $error("charger on"); // [R15]
    property p_clk;
        @(posedge clock) disable iff (reset)
        (phy_low_power_suspend && pwd_full && phy_clock_gate && !wak_lvl)
        |-> !xcvr_clock_run;
    endproperty
    a_clk: assert property (p_clk) else $error("clock runs"); // [R18]
endmodule

// >>> test/upsr_usb_peer.sv
// Far-side transmit sink that takes packet words and can stall
`timescale 1ns/1ps
module upsr_usb_peer
    import upsr_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        reset,
    input  wire logic                        tx_valid,
    input  wire logic [upsr_pkg::FIFO_W-1:0] tx_data,
    input  wire logic                        stall,
    output logic                             tx_ready
);
    import upsr_pkg::*;
    logic [FIFO_W-1:0] got[$];
    logic              phase = 1'b0;
    // Ready moves only just after an edge; stalling halves the take rate
    always @(posedge clock) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            got.push_back(tx_data);
        phase    <= reset ? 1'b0 : ~phase;
        tx_ready <= !reset && (!stall || phase);
    end
endmodule

// >>> test/upsr_port_ctrl_tb.sv
// Self-checking bench for the USB port suspend/resume control block
`timescale 1ns/1ps
module upsr_port_ctrl_tb;
    import upsr_pkg::*;
    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic              host_mode = 1'b0;
    logic              suspend_set = 1'b0;
    logic              suspend_clear = 1'b0;
    logic              port_suspend = 1'b0;
    logic [PWD_W-1:0]  phy_powerdown_bits = 5'h00;
    logic              phy_clock_gate = 1'b0;
    logic              resume_pin = 1'b0;
    logic              wakeup_pin = 1'b0;
    logic              stream_disable = 1'b0;
    logic [THR_W-1:0]  tx_fill_threshold = 6'h01;
    logic              chg_detect_enable_n = 1'b1;
    logic              hs_disconnect_detect_enable = 1'b0;
    logic              se0_seen = 1'b0;
    logic              in_valid = 1'b0;
    logic [FIFO_W-1:0] in_data = 32'h0;
    logic [LEN_W-1:0]  pkt_words = 10'h000;
    logic              pkt_start = 1'b0;
    logic              stall = 1'b0;
    logic              in_ready, tx_ready, tx_valid, tx_underrun_retry;
    logic [FIFO_W-1:0] tx_data;
    logic              phy_low_power_suspend, port_change_irq;
    logic              remote_wakeup_irq, xcvr_clock_run, drive_fs_k;
    logic              drive_se0, high_speed, sof_allowed;
    logic              hs_disc_detect_active, charger_detect_on;
    int                err_count = 0;
    int                comparisons = 0;
    int                cycles = 0;
    int                pc_n, rw_n, n;

    upsr_port_ctrl dut (
        .clock, .reset, .host_mode, .suspend_set, .suspend_clear,
        .port_suspend, .phy_powerdown_bits, .phy_clock_gate, .resume_pin,
        .wakeup_pin, .stream_disable, .tx_fill_threshold,
        .chg_detect_enable_n, .hs_disconnect_detect_enable, .se0_seen,
        .in_valid, .in_ready, .in_data, .pkt_words, .pkt_start, .tx_ready,
        .tx_valid, .tx_data, .tx_underrun_retry, .phy_low_power_suspend,
        .port_change_irq, .remote_wakeup_irq, .xcvr_clock_run, .drive_fs_k,
        .drive_se0, .high_speed, .sof_allowed, .hs_disc_detect_active,
        .charger_detect_on
    );
    upsr_usb_peer peer (.clock, .reset, .tx_valid, .tx_data, .stall,
                        .tx_ready);

    // 20 MHz clock
    always #25 clock = ~clock;

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask

    // Interrupts are one-cycle pulses, so every cycle is looked at
    task automatic watch_irqs(input int k);
        pc_n = 0;
        rw_n = 0;
        repeat (k) begin
            @(negedge clock);
            pc_n += (port_change_irq === 1'b1);
            rw_n += (remote_wakeup_irq === 1'b1);
        end
    endtask

    // Valid held until the full flag lets the word in
    task automatic put_words(input int k, input logic [31:0] base);
        for (int i = 0; i < k; i++) begin
            @(negedge clock);
            in_data = base + i;
            in_valid = 1'b1;
            repeat (50) if (in_ready !== 1'b1) @(negedge clock);
        end
        @(negedge clock);
        in_valid = 1'b0;
    endtask

    task automatic check_got(input int k, input logic [31:0] base);
        repeat (120) if (peer.got.size() < k) @(negedge clock);
        check(peer.got.size(), k);
        foreach (peer.got[i]) check(peer.got[i], base + i);
        peer.got.delete();
    endtask

    task automatic t_reset;
        check(phy_low_power_suspend, 0);
        check({port_change_irq, remote_wakeup_irq}, 0);
        check(tx_valid, 0);
        check(in_ready, 1);
        check(charger_detect_on, 0);
        chg_detect_enable_n = 1'b0;
        tick(1);
        check(charger_detect_on, 1);
    endtask

    task automatic t_dev_resume;
        port_suspend = 1'b1;
        suspend_set = 1'b1;
        tick(1);
        suspend_set = 1'b0;
        tick(2);
        check(phy_low_power_suspend, 1);
        resume_pin = 1'b1;
        repeat (10) if (phy_low_power_suspend !== 1'b0) tick(1);
        check(phy_low_power_suspend, 0);
        resume_pin = 1'b0;
        tick(6);
    endtask

    task automatic t_wakeup;
        wakeup_pin = 1'b1;
        watch_irqs(10);
        check(pc_n, 1);
        check(rw_n, 0);
        check(phy_low_power_suspend, 0);
        wakeup_pin = 1'b0;
        suspend_set = 1'b1;
        tick(1);
        suspend_set = 1'b0;
        tick(5);
        wakeup_pin = 1'b1;
        watch_irqs(10);
        check(rw_n, 1);
        wakeup_pin = 1'b0;
        tick(6);
    endtask

    task automatic t_clock_gate;
        suspend_set = 1'b1;
        tick(1);
        suspend_set = 1'b0;
        phy_powerdown_bits = PWD_ALL ^ 5'h01;
        phy_clock_gate = 1'b1;
        tick(3);
        check(xcvr_clock_run, 1);
        phy_powerdown_bits = PWD_ALL;
        tick(3);
        check(xcvr_clock_run, 0);
        wakeup_pin = 1'b1;
        tick(8);
        check(xcvr_clock_run, 1);
        wakeup_pin = 1'b0;
        phy_clock_gate = 1'b0;
        phy_powerdown_bits = 5'h00;
        suspend_clear = 1'b1;
        tick(1);
        suspend_clear = 1'b0;
        tick(6);
    endtask

    task automatic t_host_resume;
        host_mode = 1'b1;
        hs_disconnect_detect_enable = 1'b1;
        tick(1);
        check(hs_disc_detect_active, 0);
        resume_pin = 1'b1;
        repeat (10) if (drive_fs_k !== 1'b1) tick(1);
        check(drive_fs_k, 1);
        check(sof_allowed, 0);
        resume_pin = 1'b0;
        repeat (10) if (drive_se0 !== 1'b1) tick(1);
        check({drive_fs_k, drive_se0}, 1);
        port_suspend = 1'b0;
        tick(3);
        check({drive_se0, high_speed, sof_allowed}, 4);
        se0_seen = 1'b1;
        for (n = 0; n < 60 && sof_allowed !== 1'b1; n++) tick(1);
        check(n >= SOF_IDLE_CYC && n <= SOF_IDLE_CYC + 4, 1);
        check({high_speed, drive_se0}, 2);
        check(hs_disc_detect_active, 1);
        se0_seen = 1'b0;
    endtask

    // Fill until refused with no packet pending, then drain while stalling
    task automatic t_fill;
        stall = 1'b1;
        for (n = 0; n < 40 && in_ready === 1'b1; n++) begin
            in_data = 32'h100 + n;
            in_valid = 1'b1;
            tick(1);
        end
        in_valid = 1'b0;
        check(n, FIFO_DEPTH);
        stream_disable = 1'b1;
        pkt_words = 10'd32;
        pkt_start = 1'b1;
        check_got(32, 32'h100);
        pkt_start = 1'b0;
        check(tx_valid, 0);
        stall = 1'b0;
    endtask

    task automatic t_stream;
        pkt_words = 10'd8;
        put_words(7, 32'h200);
        pkt_start = 1'b1;
        tick(10);
        check(tx_valid, 0);
        put_words(1, 32'h207);
        check_got(8, 32'h200);
        pkt_start = 1'b0;
    endtask

    // Threshold reached early, then the FIFO runs dry in mid-packet
    task automatic t_underrun;
        stream_disable = 1'b0;
        tx_fill_threshold = 6'h04;
        put_words(3, 32'h300);
        pkt_start = 1'b1;
        tick(10);
        check(tx_valid, 0);
        put_words(1, 32'h303);
        pc_n = 0;
        repeat (40) begin
            @(negedge clock);
            pc_n += (tx_underrun_retry === 1'b1);
        end
        check(pc_n, 1);
        check_got(4, 32'h300);
        pkt_start = 1'b0;
        check(tx_valid, 0);
    endtask

    // Main sequence
    initial begin
        tick(6);
        reset = 1'b0;
        tick(1);
        t_reset;
        t_dev_resume;
        t_wakeup;
        t_clock_gate;
        t_host_resume;
        t_fill;
        t_stream;
        t_underrun;
        stop_test;
    end
endmodule
